// *** verilog/pec_parity_ctrl.sv ***
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module pec_parity_ctrl (
  input wire logic sys_clk_i, // 10 MHz system clock
  input wire logic rstn_i, // synchronous reset, active low
  // AXI4-Lite slave
  input wire logic [3:0] s_awaddr_i, // write address
  input wire logic s_awvalid_i, // write address valid
  output logic s_awready_o, // write address ready
  input wire logic [31:0] s_wdata_i, // write data
  input wire logic [3:0] s_wstrb_i, // write byte strobes
  input wire logic s_wvalid_i, // write data valid
  output logic s_wready_o, // write data ready
  output logic [1:0] s_bresp_o, // write response
  output logic s_bvalid_o, // write response valid
  input wire logic s_bready_i, // write response ready
  input wire logic [3:0] s_araddr_i, // read address
  input wire logic s_arvalid_i, // read address valid
  output logic s_arready_o, // read address ready
  output logic [31:0] s_rdata_o, // read data
  output logic [1:0] s_rresp_o, // read response
  output logic s_rvalid_o, // read data valid
  input wire logic s_rready_i, // read data ready
  // backplane side, strobes active high, already synchronous
  input wire logic [17:0] bdal_i, // address/data lines as received
  input wire logic bsync_i, // bus sync strobe
  input wire logic bdin_i, // bus input strobe
  input wire logic bdout_i, // bus output strobe
  input wire logic brply_i, // bus reply
  input wire logic binit_i, // bus initialize
  output logic [15:0] bdal_o, // data driven during a register read
  output logic [15:0] bdal_oe_n_o, // low where data lines are driven
  output logic bdal16_o, // error / write-wrong-parity line, asserted high
  output logic bdal16_oe_n_o, // low while the error line is driven
  output logic bdal17_o, // parity enable line, asserted high
  output logic bdal17_oe_n_o, // low while the enable line is driven
  output logic brply_o, // reply for a register access
  output logic csr_active_o // register selected in current bus cycle
);

  ////////////////////////////////////////////////////////////////////////////
  // backplane strobe sampling and edge detection

  pec_pkg::pec_strobes_t strb_reg;
  pec_pkg::pec_strobes_t strb_now;
  logic sync_rise;
  logic din_rise;
  logic dout_rise;
  logic rply_rise;

  // bundle the pins once so every edge is taken from the same sample
  assign strb_now = '{sync: bsync_i, din: bdin_i, dout: bdout_i, rply: brply_i,
                      init: binit_i};
  assign sync_rise = strb_now.sync & ~strb_reg.sync;
  assign din_rise = strb_now.din & ~strb_reg.din;
  assign dout_rise = strb_now.dout & ~strb_reg.dout;
  assign rply_rise = strb_now.rply & ~strb_reg.rply;

  // previous strobe levels
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      strb_reg <= '0;
    end else begin
      strb_reg <= strb_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address phase: latch address and decide whether this cycle is ours

  logic [3:0] jumper_reg;
  logic [17:0] cyc_addr_reg;
  logic sel_reg;
  logic addr_hit;
  logic [6:0] err_addr_reg;
  logic err_flag_reg;

  // low select bits A04-A01 compared against the jumper setting
  assign addr_hit = ((bdal_i & pec_pkg::CSR_BASE_MASK) == pec_pkg::CSR_BASE_ADDR) &&
                    (bdal_i[4:1] == jumper_reg);

  // address of the cycle and our selection, sampled on sync leading edge
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      cyc_addr_reg <= 18'h00000;
      sel_reg <= 1'b0;
    end else if (sync_rise) begin
      cyc_addr_reg <= bdal_i;
      sel_reg <= addr_hit;
    end else if (!strb_now.sync) begin
      sel_reg <= 1'b0;
    end
  end

  // upper address capture; frozen while an error is held so its block survives
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      err_addr_reg <= 7'h00;
    end else if (sync_rise && !err_flag_reg) begin
      err_addr_reg <= bdal_i[pec_pkg::ADR_CAP_MSB:pec_pkg::ADR_CAP_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control and status bits

  logic enable_reg;
  logic wwp_reg;
  logic bus_wr;
  logic bus_rd;
  logic axi_wr_csr;
  logic axi_wr_jmp;
  logic [31:0] axi_wdata;
  logic axi_rd_csr;
  logic csr_read;
  logic err_set;
  logic [15:0] csr_value;

  assign bus_wr = sel_reg & dout_rise;
  assign bus_rd = sel_reg & din_rise;
  assign csr_read = bus_rd | axi_rd_csr;
  // error reported by memory at reply of a read, only from memory cycles
  assign err_set = rply_rise & strb_now.din & bdal_i[16] & ~sel_reg;

  // unused bits tie to zero and hold no storage
  always_comb begin
    csr_value = 16'h0000;
    csr_value[pec_pkg::ENABLE_BIT] = enable_reg;
    csr_value[pec_pkg::WWP_BIT] = wwp_reg;
    csr_value[pec_pkg::ERRADR_MSB:pec_pkg::ERRADR_LSB] = err_addr_reg;
    csr_value[pec_pkg::ERRFLAG_BIT] = err_flag_reg;
  end

  // enable and write-wrong-parity follow processor writes; init clears both
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || strb_now.init) begin
      enable_reg <= 1'b0;
      wwp_reg <= 1'b0;
    end else if (bus_wr) begin
      enable_reg <= bdal_i[pec_pkg::ENABLE_BIT];
      wwp_reg <= bdal_i[pec_pkg::WWP_BIT];
    end else if (axi_wr_csr) begin
      enable_reg <= axi_wdata[pec_pkg::ENABLE_BIT];
      wwp_reg <= axi_wdata[pec_pkg::WWP_BIT];
    end
  end

  // error flag: a new error in the clearing cycle wins over the read
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || strb_now.init) begin
      err_flag_reg <= 1'b0;
    end else if (err_set) begin
      err_flag_reg <= 1'b1;
    end else if (csr_read) begin
      err_flag_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // backplane drivers

  logic [15:0] bdal_next;
  logic rd_drive;

  assign rd_drive = sel_reg & strb_now.din;
  // word frozen at the input strobe edge, so the read that clears the flag still shows it
  assign bdal_next = bus_rd ? csr_value : (rd_drive ? bdal_o : 16'h0000);

  // all pin outputs registered; one cycle of lag against the strobes
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      bdal_o <= 16'h0000;
      bdal_oe_n_o <= 16'hFFFF;
      bdal16_o <= 1'b0;
      bdal16_oe_n_o <= 1'b1;
      bdal17_o <= 1'b0;
      bdal17_oe_n_o <= 1'b1;
      brply_o <= 1'b0;
      csr_active_o <= 1'b0;
    end else begin
      bdal_o <= bdal_next;
      bdal_oe_n_o <= {16{~rd_drive}};
      bdal17_o <= enable_reg & strb_now.din;
      bdal17_oe_n_o <= ~(enable_reg & strb_now.din);
      bdal16_o <= wwp_reg & strb_now.dout;
      bdal16_oe_n_o <= ~(wwp_reg & strb_now.dout);
      brply_o <= sel_reg & (strb_now.din | strb_now.dout);
      csr_active_o <= sel_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: write channel, takes address and data in either order

  logic aw_held_reg;
  logic w_held_reg;
  logic [3:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_go;
  logic [3:0] wr_addr;
  logic [31:0] wr_data;

  // a register changes once, in the cycle both halves are held, from the held copies
  assign wr_go = aw_held_reg & w_held_reg & ~s_bvalid_o;
  assign wr_addr = aw_addr_reg;
  assign wr_data = w_data_reg;
  assign axi_wr_csr = wr_go && (wr_addr == pec_pkg::CSR_OFFSET) && w_strb_reg[0];
  assign axi_wdata = wr_data;
  assign axi_wr_jmp = wr_go && (wr_addr == pec_pkg::BUSADDR_OFFSET);

  // hold whichever half arrives first until the other turns up
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      s_awready_o <= 1'b0;
      s_wready_o <= 1'b0;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_bvalid_o <= 1'b0;
      s_bresp_o <= pec_pkg::RESP_OKAY;
    end else begin
      s_awready_o <= ~aw_held_reg & ~s_awready_o & ~s_bvalid_o;
      s_wready_o <= ~w_held_reg & ~s_wready_o & ~s_bvalid_o;
      if (s_awvalid_i && s_awready_o) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_awaddr_i;
      end
      if (s_wvalid_i && s_wready_o) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_wdata_i;
        w_strb_reg <= s_wstrb_i;
      end
      if (aw_held_reg && w_held_reg && !s_bvalid_o) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_bvalid_o <= 1'b1;
        s_bresp_o <= (aw_addr_reg == pec_pkg::CSR_OFFSET ||
                      aw_addr_reg == pec_pkg::BUSADDR_OFFSET) ?
                     pec_pkg::RESP_OKAY : pec_pkg::RESP_SLVERR;
      end else if (s_bvalid_o && s_bready_i) begin
        s_bvalid_o <= 1'b0;
      end
    end
  end

  logic wr_commit;
  assign wr_commit = aw_held_reg & w_held_reg & ~s_bvalid_o;

  // jumper setting, software stands in for the wired straps
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      jumper_reg <= pec_pkg::JUMPER_RESET;
    end else if (axi_wr_jmp && wr_commit && w_strb_reg[0]) begin
      jumper_reg <= wr_data[4:1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: read channel

  logic ar_take;
  logic [31:0] rd_word;
  logic rd_ok;

  assign ar_take = s_arvalid_i & s_arready_o;
  assign axi_rd_csr = ar_take && (s_araddr_i == pec_pkg::CSR_OFFSET);
  assign rd_ok = (s_araddr_i == pec_pkg::CSR_OFFSET) ||
                 (s_araddr_i == pec_pkg::BUSADDR_OFFSET);
  assign rd_word = (s_araddr_i == pec_pkg::CSR_OFFSET) ? {16'h0000, csr_value} :
                   (s_araddr_i == pec_pkg::BUSADDR_OFFSET) ? {27'h0, jumper_reg, 1'b0} :
                   32'h0000_0000;

  // one read in flight; arready drops while the answer waits
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      s_arready_o <= 1'b0;
      s_rvalid_o <= 1'b0;
      s_rdata_o <= 32'h0000_0000;
      s_rresp_o <= pec_pkg::RESP_OKAY;
    end else begin
      s_arready_o <= ~s_rvalid_o; // never waits on arvalid, so a waiting request cannot stall
      if (ar_take) begin
        s_arready_o <= 1'b0;
        s_rvalid_o <= 1'b1;
        s_rdata_o <= rd_word;
        s_rresp_o <= rd_ok ? pec_pkg::RESP_OKAY : pec_pkg::RESP_SLVERR;
      end else if (s_rvalid_o && s_rready_i) begin
        s_rvalid_o <= 1'b0;
      end
    end
  end

endmodule : pec_parity_ctrl

// *** verilog/pec_pkg.sv ***
package pec_pkg;

  // register map, byte addresses on the AXI4-Lite side
  localparam logic [3:0] CSR_OFFSET = 4'h0;
  localparam logic [3:0] BUSADDR_OFFSET = 4'h4;

  // control and status register field positions
  localparam int ENABLE_BIT = 0;
  localparam int WWP_BIT = 2;
  localparam int ERRADR_LSB = 5;
  localparam int ERRADR_MSB = 11;
  localparam int ERRFLAG_BIT = 15;

  // backplane address bits captured on each sync strobe while no error is held
  localparam int ADR_CAP_LSB = 11;
  localparam int ADR_CAP_MSB = 17;

  // fixed part of the register's bus address, low select bits come from jumpers
  localparam logic [17:0] CSR_BASE_ADDR = 18'h3F440;
  localparam logic [17:0] CSR_BASE_MASK = 18'h3FFE1;

  // reset values
  localparam logic [31:0] CSR_RESET = 32'h0000_0000;
  localparam logic [3:0] JUMPER_RESET = 4'h0;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // backplane strobes sampled from the pins, all active high here
  typedef struct packed {
    logic sync;
    logic din;
    logic dout;
    logic rply;
    logic init;
  } pec_strobes_t;

endpackage : pec_pkg

// *** dv/pec_chk_sva.sv ***
`timescale 1ns/1ps
// assertions on the register bus answers and the backplane drives
module pec_chk (
  input wire logic sys_clk_i, // clock
  input wire logic rstn_i, // reset, low
  input wire logic [3:0] s_araddr_i, // read address
  input wire logic s_arvalid_i, // read valid
  input wire logic s_arready_o, // read ready
  input wire logic [31:0] s_rdata_o, // read data
  input wire logic [1:0] s_rresp_o, // read response
  input wire logic s_rvalid_o, // read data valid
  input wire logic bdin_i, // input strobe
  input wire logic bdout_i, // output strobe
  input wire logic [15:0] bdal_oe_n_o, // data enables
  input wire logic bdal16_o, // error line
  input wire logic bdal16_oe_n_o, // error enable
  input wire logic bdal17_o, // parity enable line
  input wire logic bdal17_oe_n_o, // its enable
  input wire logic brply_o, // reply
  input wire logic csr_active_o // selected
);
  logic rd_csr_reg; // pending read targets the status register
  wire ar_take = s_arvalid_i && s_arready_o;
  wire ar_ok = ar_take && !s_araddr_i[3] && s_araddr_i[1:0] == 2'h0;
  // the target is kept because read data is judged a cycle after the take
  always_ff @(posedge sys_clk_i) if (ar_take) rd_csr_reg <= s_araddr_i == pec_pkg::CSR_OFFSET;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////
  rd_bad_a: assert property (ar_take && s_araddr_i[3] |=> s_rresp_o == pec_pkg::RESP_SLVERR)
    else $error("unmapped read not refused");
  rd_ok_a: assert property (ar_ok |-> ##1 s_rvalid_o && s_rresp_o == pec_pkg::RESP_OKAY)
    else $error("mapped read refused");
  zero_bits_a: assert property (s_rvalid_o && rd_csr_reg |-> (s_rdata_o & 32'hFFFF_701A) == 0)
    else $error("unused bits not zero");
  en_din_a: assert property (!bdal17_oe_n_o |-> bdal17_o && $past(bdin_i))
    else $error("enable line driven outside input strobe");
  wwp_dout_a: assert property (!bdal16_oe_n_o |-> bdal16_o && $past(bdout_i))
    else $error("error line driven outside output strobe");
  data_sel_a: assert property (bdal_oe_n_o != 16'hFFFF |-> csr_active_o && $past(bdin_i))
    else $error("data driven while not selected");
  rply_sel_a: assert property (brply_o |-> csr_active_o && ($past(bdin_i) || $past(bdout_i)))
    else $error("reply while not selected");
  rply_end_a: assert property ($fell(bdin_i) && !bdout_i |=> !brply_o)
    else $error("reply held after strobe");
endmodule : pec_chk
bind pec_parity_ctrl pec_chk chk_u (.*);

// *** dv/pec_bus_model.sv ***
`timescale 1ns/1ps
// processor and parity memory on the backplane; strobes are levels, asserted high
module pec_bus_model (
  input wire logic clk_i, // clock
  input wire logic [15:0] d_i, // controller data
  input wire logic [15:0] d_oe_n_i, // data enables, low drives
  input wire logic [1:0] hi_i, // controller lines 17:16
  input wire logic [1:0] hi_oe_n_i, // their enables
  input wire logic rply_i, // controller reply
  output logic [17:0] bdal_o, // resolved line levels
  output logic sync_o, // sync strobe
  output logic din_o, // input strobe
  output logic dout_o, // output strobe
  output logic rply_o // resolved reply
);
  logic [17:0] drv_reg = 18'h0; // lines this model asserts
  logic mrply_reg = 1'b0; // memory reply
  bit bad_mem [0:262143]; // words stored with wrong parity
  // wired-or bus: a released line is pulled back to negated
  assign bdal_o = drv_reg | {hi_i & ~hi_oe_n_i, d_i & ~d_oe_n_i};
  assign rply_o = mrply_reg | rply_i;
  initial {sync_o, din_o, dout_o} = 3'b000;
  ////////////////////////////////////////
  // one bus cycle; mem says whether the memory answers it
  task automatic cyc(input logic [17:0] a, input logic wr, input logic [15:0] wd,
                     input logic mem, output logic [17:0] seen);
    @(posedge clk_i);
    sync_o <= 1'b1;
    drv_reg <= a;
    @(posedge clk_i);
    drv_reg <= wr ? {2'b00, wd} : 18'h0;
    dout_o <= wr;
    din_o <= !wr;
    repeat (2) @(posedge clk_i);
    mrply_reg <= mem;
    if (mem && !wr)
      drv_reg[16] <= bad_mem[a]; // a bad word shows on the error line
    do @(posedge clk_i); while (!rply_o);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    seen = bdal_o;
    if (mem && wr)
      bad_mem[a] = seen[16];
    @(posedge clk_i);
    {din_o, dout_o, mrply_reg} <= 3'b000;
    drv_reg <= 18'h0;
    @(posedge clk_i);
    sync_o <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : cyc
endmodule : pec_bus_model

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
// register bus and backplane cycles against the parity controller
module tb_top;
  localparam logic [17:0] CSR_A = pec_pkg::CSR_BASE_ADDR;
  localparam logic [17:0] MEM_A = 18'h04800; // address field 7'h09
  logic sys_clk_i = 1'b0, rstn_i = 1'b0, binit_i = 1'b0;
  logic [3:0] s_awaddr_i = 4'h0, s_araddr_i = 4'h0, s_wstrb_i = 4'hF;
  logic [31:0] s_wdata_i = 32'h0, s_rdata_o;
  logic s_awvalid_i = 1'b0, s_wvalid_i = 1'b0, s_arvalid_i = 1'b0;
  logic s_bready_i = 1'b1, s_rready_i = 1'b1; // always ready for answers
  logic [1:0] s_bresp_o, s_rresp_o;
  logic s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o;
  logic [17:0] bdal_i;
  logic bsync_i, bdin_i, bdout_i, brply_i, brply_o, csr_active_o;
  logic [15:0] bdal_o, bdal_oe_n_o;
  logic bdal16_o, bdal16_oe_n_o, bdal17_o, bdal17_oe_n_o;
  int bad_count = 0, checks_done = 0, cycles = 0;
  pec_parity_ctrl dut_u (.*);
  pec_bus_model pm_u (.clk_i(sys_clk_i), .d_i(bdal_o), .d_oe_n_i(bdal_oe_n_o),
    .hi_i({bdal17_o, bdal16_o}), .hi_oe_n_i({bdal17_oe_n_o, bdal16_oe_n_o}),
    .rply_i(brply_o), .bdal_o(bdal_i), .sync_o(bsync_i), .din_o(bdin_i),
    .dout_o(bdout_i), .rply_o(brply_i));
  initial forever #50 sys_clk_i = ~sys_clk_i;
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  // address and data are offered together and each is released once taken
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge sys_clk_i);
    s_awaddr_i <= a;
    s_wdata_i <= d;
    {s_awvalid_i, s_wvalid_i} <= 2'b11;
    fork
      begin
        do @(posedge sys_clk_i); while (!s_awready_o);
        s_awvalid_i <= 1'b0;
      end
      begin
        do @(posedge sys_clk_i); while (!s_wready_o);
        s_wvalid_i <= 1'b0;
      end
    join
    do @(posedge sys_clk_i); while (!s_bvalid_o);
    chk(32'(s_bresp_o), 32'(er));
  endtask : axw
  task automatic axr(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge sys_clk_i);
    s_araddr_i <= a;
    s_arvalid_i <= 1'b1;
    do @(posedge sys_clk_i); while (!s_arready_o);
    s_arvalid_i <= 1'b0;
    do @(posedge sys_clk_i); while (!s_rvalid_o);
    chk(s_rdata_o, ed);
    chk(32'(s_rresp_o), 32'(er));
  endtask : axr
  // ex holds lines 17 and 16 above the data word as seen at reply time
  task automatic bp(input logic [17:0] a, input logic wr, input logic [15:0] d,
                    input logic mem, input logic [17:0] ex);
    logic [17:0] s;
    pm_u.cyc(a, wr, d, mem, s);
    chk(32'(s), 32'(ex));
  endtask : bp
  // watchdog: the sequence needs well under a thousand cycles
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      results();
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    axr(4'h0, 32'h0, pec_pkg::RESP_OKAY);
    axr(4'h4, 32'h0, pec_pkg::RESP_OKAY);
    axr(4'h8, 32'h0, pec_pkg::RESP_SLVERR);
    axw(4'hC, 32'hFFFF, pec_pkg::RESP_SLVERR);
    bp(CSR_A, 1'b1, 16'h0005, 1'b0, 18'h10005);
    bp(CSR_A, 1'b0, 16'h0, 1'b0, 18'h20FC5);
    bp(MEM_A, 1'b1, 16'h1234, 1'b1, 18'h11234);
    bp(CSR_A, 1'b1, 16'h0001, 1'b0, 18'h00001);
    bp(MEM_A, 1'b0, 16'h0, 1'b1, 18'h30000);
    bp(18'h08000, 1'b0, 16'h0, 1'b1, 18'h20000);
    bp(CSR_A, 1'b0, 16'h0, 1'b0, 18'h28121);
    bp(CSR_A, 1'b0, 16'h0, 1'b0, 18'h20FC1);
    axr(4'h0, 32'h0FC1, pec_pkg::RESP_OKAY);
    bp(CSR_A, 1'b1, 16'h0005, 1'b0, 18'h10005);
    bp(MEM_A, 1'b0, 16'h0, 1'b1, 18'h30000);
    @(posedge sys_clk_i);
    binit_i <= 1'b1;
    @(posedge sys_clk_i);
    binit_i <= 1'b0;
    bp(CSR_A, 1'b0, 16'h0, 1'b0, 18'h00FC0);
    bp(MEM_A, 1'b0, 16'h0, 1'b1, 18'h10000);
    axw(4'h4, 32'h6, pec_pkg::RESP_OKAY);
    axr(4'h4, 32'h6, pec_pkg::RESP_OKAY);
    bp(CSR_A, 1'b0, 16'h0, 1'b1, 18'h0);
    bp(CSR_A | 18'h6, 1'b0, 16'h0, 1'b0, 18'h08120);
    axw(4'h0, 32'h5, pec_pkg::RESP_OKAY);
    axr(4'h0, 32'h0125, pec_pkg::RESP_OKAY);
    results();
  end
endmodule : tb_top
